// ---- include/rfcs_defines.vh ----
// constants of the rf channel select and servo offset register bank
// Function
// - selector 1001 loads left channel; applies when sector high, track side low
// - selector 1010 loads right channel; applies when both pins high
// - selector 1000 loads data channel; applies when sector pin low
// - bits 7,5,3,1 mute inputs d,c,b,a; one mutes, zero passes
// - bits 6,4,2,0 invert inputs d,c,b,a; one inverts, zero passes
// - selector 1011 loads radial offset; bits 11..10 hold low frequency code
// - low frequency code gives 0/5/10/15 mV normal, 0/15/30/45 mV triple
// - radial bit 9 picks normal or triple scale for all offset codes
// - radial bit 8 picks fast track bandwidth, 600 kHz or 1.2 MHz
// - radial bits 7..4 hold input e code, 0..20 or 0..60 mV
// - radial bits 3..0 hold input f code, same ranges as e
// - central register: test bit 11, test selector 10..8, a 7..4, b 3..0
`ifndef RFCS_DEFINES_VH
`define RFCS_DEFINES_VH

// ----------------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------------
`define RFCS_IDX_DATA 4'h8
`define RFCS_IDX_LEFT 4'h9
`define RFCS_IDX_RIGHT 4'hA
`define RFCS_IDX_RADIAL 4'hB
`define RFCS_IDX_CENTRAL 4'hC
`define RFCS_ADDR_CMD 12'h000
`define RFCS_ADDR_STATUS 12'h040
`define RFCS_ADDR_MASK 12'hFFC

// ----------------------------------------------------------------------------
// word fields
// ----------------------------------------------------------------------------
`define RFCS_SEL_HI 15
`define RFCS_SEL_LO 12
`define RFCS_CH_HI 7
`define RFCS_LF_HI 11
`define RFCS_LF_LO 10
`define RFCS_SCALE_BIT 9
`define RFCS_FTC_BIT 8
`define RFCS_E_HI 7
`define RFCS_E_LO 4
`define RFCS_F_HI 3
`define RFCS_F_LO 0
`define RFCS_TST_BIT 11
`define RFCS_TSV_HI 10
`define RFCS_TSV_LO 8
`define RFCS_CA_HI 7
`define RFCS_CA_LO 4
`define RFCS_CB_HI 3
`define RFCS_CB_LO 0

// ----------------------------------------------------------------------------
// reset values and offset scales
// ----------------------------------------------------------------------------
`define RFCS_RST_CH 8'h00
`define RFCS_RST_RAD 12'h000
`define RFCS_RST_CEN 12'h000
`define RFCS_LF_STEP_NORM 6'h05
`define RFCS_LF_STEP_TRIP 6'h0F
`define RFCS_FS_NORM 6'h14
`define RFCS_FS_TRIP 6'h3C
`define RFCS_FTC_LO_KHZ 11'h258
`define RFCS_FTC_HI_KHZ 11'h4B0

// ----------------------------------------------------------------------------
// applied channel codes and ahb
// ----------------------------------------------------------------------------
`define RFCS_CHAN_DATA 2'h0
`define RFCS_CHAN_LEFT 2'h1
`define RFCS_CHAN_RIGHT 2'h2
`define RFCS_CHAN_NONE 2'h3
`define RFCS_HRESP_OKAY 1'b0

`endif

// ---- rtl/rfcs_chan_switch.v ----
// picks the channel selection that the sector pins call for
`timescale 1ns/1ns
`include "rfcs_defines.vh"
module rfcs_chan_switch (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // synchronised pins
  input wire sector_type,
  input wire track_side,
  // stored channel settings
  input wire [7:0] data_sel,
  input wire [7:0] left_sel,
  input wire [7:0] right_sel,
  // applied controls
  output reg [3:0] silence,
  output reg [3:0] polarity_flip,
  output reg [1:0] active_channel
);

  reg [7:0] picked;
  reg [1:0] next_channel;
  wire [3:0] next_silence;
  wire [3:0] next_flip;

  // ----------------------------------------------------------------------------
  // channel choice
  // ----------------------------------------------------------------------------
  always @* begin
    picked = data_sel;
    next_channel = `RFCS_CHAN_DATA;
    if (!sector_type) begin
      picked = data_sel;
      next_channel = `RFCS_CHAN_DATA;
    end else if (!track_side) begin
      picked = left_sel;
      next_channel = `RFCS_CHAN_LEFT;
    end else begin
      picked = right_sel;
      next_channel = `RFCS_CHAN_RIGHT;
    end
  end

  // ----------------------------------------------------------------------------
  // per input mute and polarity
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_in
      assign next_silence[i] = picked[2*i+1];
      assign next_flip[i] = picked[2*i];
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      silence <= 4'h0;
      polarity_flip <= 4'h0;
      active_channel <= `RFCS_CHAN_NONE;
    end else begin
      silence <= next_silence;
      polarity_flip <= next_flip;
      active_channel <= next_channel;
    end
  end

endmodule

// ---- rtl/rfcs_regs.v ----
// ahb-lite register bank for rf channel select and servo offsets
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "rfcs_defines.vh"
module rfcs_regs (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // sector pins
  input wire sector_type_pin,
  input wire track_side_pin,
  // applied channel controls
  output wire input_a_silence,
  output wire input_a_polarity_flip,
  output wire input_b_silence,
  output wire input_b_polarity_flip,
  output wire input_c_silence,
  output wire input_c_polarity_flip,
  output wire input_d_silence,
  output wire input_d_polarity_flip,
  output wire [1:0] active_channel,
  // radial offset and scale
  output reg [1:0] low_freq_path_offset_code,
  output reg offset_scale_select,
  output reg fast_track_bandwidth_select,
  output reg [3:0] radial_e_offset_code,
  output reg [3:0] radial_f_offset_code,
  output reg [5:0] low_freq_offset_mv,
  output reg [5:0] offset_full_scale_mv,
  output reg [10:0] fast_track_bandwidth_khz,
  // central offset a and b
  output reg phase_filter_rf_test_bit,
  output reg [2:0] servo_test_selector,
  output reg [3:0] central_a_offset_code,
  output reg [3:0] central_b_offset_code
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  reg [7:0] data_channel_input_switch;
  reg [7:0] left_channel_input_switch;
  reg [7:0] right_channel_input_switch;
  reg [11:0] radial_offset_and_scale;
  reg [11:0] central_offset_ab_and_test;
  reg wr_pend;
  reg [11:0] wr_addr;
  reg sector_meta;
  reg sector_sync;
  reg track_meta;
  reg track_sync;
  reg [3:0] last_selector;
  reg [31:0] next_rdata;
  reg [7:0] next_data_channel_input_switch;
  reg [7:0] next_left_channel_input_switch;
  reg [7:0] next_right_channel_input_switch;
  reg [11:0] next_radial_offset_and_scale;
  reg [11:0] next_central_offset_ab_and_test;
  reg [3:0] next_last_selector;
  wire addr_take;
  wire [11:0] addr_lo;
  wire [3:0] word_sel;
  wire cmd_write;
  wire [3:0] sw_silence;
  wire [3:0] sw_flip;
  wire [5:0] next_low_freq_offset_mv;
  wire [5:0] next_full_scale_mv;
  wire [10:0] next_bandwidth_khz;

  // ----------------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------------
  function sel_hit;
    input [3:0] sel;
    input [3:0] idx;
    begin
      sel_hit = (sel == idx);
    end
  endfunction

  function [11:0] idx_addr;
    input [3:0] idx;
    begin
      idx_addr = {6'h00, idx, 2'h0};
    end
  endfunction

  function [31:0] chan_word;
    input [3:0] idx;
    input [7:0] bits;
    begin
      chan_word = {16'h0000, idx, 4'h0, bits};
    end
  endfunction

  function [5:0] lf_mv;
    input [1:0] code;
    input triple;
    reg [5:0] step;
    begin
      step = triple ? `RFCS_LF_STEP_TRIP : `RFCS_LF_STEP_NORM;
      case (code)
        2'h0: lf_mv = 6'h00;
        2'h1: lf_mv = step;
        2'h2: lf_mv = step + step;
        default: lf_mv = step + step + step;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------------
  // ahb address phase
  // ----------------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = `RFCS_HRESP_OKAY;
  assign addr_take = hsel & hready & htrans[1];
  assign addr_lo = haddr[11:0] & `RFCS_ADDR_MASK;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else if (hready) begin
      wr_pend <= addr_take & hwrite;
      wr_addr <= addr_lo;
    end
  end

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sector_meta <= 1'b0;
      sector_sync <= 1'b0;
      track_meta <= 1'b0;
      track_sync <= 1'b0;
    end else begin
      sector_meta <= sector_type_pin;
      sector_sync <= sector_meta;
      track_meta <= track_side_pin;
      track_sync <= track_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // command word decode and register load
  // ----------------------------------------------------------------------------
  assign word_sel = hwdata[`RFCS_SEL_HI:`RFCS_SEL_LO];
  assign cmd_write = wr_pend & (wr_addr == `RFCS_ADDR_CMD);

  always @* begin
    next_data_channel_input_switch = data_channel_input_switch;
    next_left_channel_input_switch = left_channel_input_switch;
    next_right_channel_input_switch = right_channel_input_switch;
    next_radial_offset_and_scale = radial_offset_and_scale;
    next_central_offset_ab_and_test = central_offset_ab_and_test;
    next_last_selector = last_selector;
    if (cmd_write) begin
      next_last_selector = word_sel;
      if (sel_hit(word_sel, `RFCS_IDX_DATA)) begin
        next_data_channel_input_switch = hwdata[`RFCS_CH_HI:0];
      end else if (sel_hit(word_sel, `RFCS_IDX_LEFT)) begin
        next_left_channel_input_switch = hwdata[`RFCS_CH_HI:0];
      end else if (sel_hit(word_sel, `RFCS_IDX_RIGHT)) begin
        next_right_channel_input_switch = hwdata[`RFCS_CH_HI:0];
      end else if (sel_hit(word_sel, `RFCS_IDX_RADIAL)) begin
        next_radial_offset_and_scale = hwdata[`RFCS_LF_HI:0];
      end else if (sel_hit(word_sel, `RFCS_IDX_CENTRAL)) begin
        next_central_offset_ab_and_test = hwdata[`RFCS_TST_BIT:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_channel_input_switch <= `RFCS_RST_CH;
      left_channel_input_switch <= `RFCS_RST_CH;
      right_channel_input_switch <= `RFCS_RST_CH;
      radial_offset_and_scale <= `RFCS_RST_RAD;
      central_offset_ab_and_test <= `RFCS_RST_CEN;
      last_selector <= 4'h0;
    end else begin
      data_channel_input_switch <= next_data_channel_input_switch;
      left_channel_input_switch <= next_left_channel_input_switch;
      right_channel_input_switch <= next_right_channel_input_switch;
      radial_offset_and_scale <= next_radial_offset_and_scale;
      central_offset_ab_and_test <= next_central_offset_ab_and_test;
      last_selector <= next_last_selector;
    end
  end

  // ----------------------------------------------------------------------------
  // channel selection applied per sector pins
  // ----------------------------------------------------------------------------
  rfcs_chan_switch u_switch (
    .hclk(hclk),
    .hresetn(hresetn),
    .sector_type(sector_sync),
    .track_side(track_sync),
    .data_sel(data_channel_input_switch),
    .left_sel(left_channel_input_switch),
    .right_sel(right_channel_input_switch),
    .silence(sw_silence),
    .polarity_flip(sw_flip),
    .active_channel(active_channel)
  );

  assign input_a_silence = sw_silence[0];
  assign input_b_silence = sw_silence[1];
  assign input_c_silence = sw_silence[2];
  assign input_d_silence = sw_silence[3];
  assign input_a_polarity_flip = sw_flip[0];
  assign input_b_polarity_flip = sw_flip[1];
  assign input_c_polarity_flip = sw_flip[2];
  assign input_d_polarity_flip = sw_flip[3];

  // ----------------------------------------------------------------------------
  // servo offset outputs
  // ----------------------------------------------------------------------------
  assign next_low_freq_offset_mv = lf_mv(radial_offset_and_scale[`RFCS_LF_HI:`RFCS_LF_LO],
    radial_offset_and_scale[`RFCS_SCALE_BIT]);
  assign next_full_scale_mv = radial_offset_and_scale[`RFCS_SCALE_BIT] ?
    `RFCS_FS_TRIP : `RFCS_FS_NORM;
  assign next_bandwidth_khz = radial_offset_and_scale[`RFCS_FTC_BIT] ?
    `RFCS_FTC_HI_KHZ : `RFCS_FTC_LO_KHZ;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_freq_path_offset_code <= 2'h0;
      offset_scale_select <= 1'b0;
      fast_track_bandwidth_select <= 1'b0;
      radial_e_offset_code <= 4'h0;
      radial_f_offset_code <= 4'h0;
      low_freq_offset_mv <= 6'h00;
      offset_full_scale_mv <= `RFCS_FS_NORM;
      fast_track_bandwidth_khz <= `RFCS_FTC_LO_KHZ;
      phase_filter_rf_test_bit <= 1'b0;
      servo_test_selector <= 3'h0;
      central_a_offset_code <= 4'h0;
      central_b_offset_code <= 4'h0;
    end else begin
      low_freq_path_offset_code <=
        radial_offset_and_scale[`RFCS_LF_HI:`RFCS_LF_LO];
      offset_scale_select <= radial_offset_and_scale[`RFCS_SCALE_BIT];
      fast_track_bandwidth_select <= radial_offset_and_scale[`RFCS_FTC_BIT];
      radial_e_offset_code <= radial_offset_and_scale[`RFCS_E_HI:`RFCS_E_LO];
      radial_f_offset_code <= radial_offset_and_scale[`RFCS_F_HI:`RFCS_F_LO];
      low_freq_offset_mv <= next_low_freq_offset_mv;
      offset_full_scale_mv <= next_full_scale_mv;
      fast_track_bandwidth_khz <= next_bandwidth_khz;
      phase_filter_rf_test_bit <= central_offset_ab_and_test[`RFCS_TST_BIT];
      servo_test_selector <=
        central_offset_ab_and_test[`RFCS_TSV_HI:`RFCS_TSV_LO];
      central_a_offset_code <=
        central_offset_ab_and_test[`RFCS_CA_HI:`RFCS_CA_LO];
      central_b_offset_code <=
        central_offset_ab_and_test[`RFCS_CB_HI:`RFCS_CB_LO];
    end
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    if (addr_lo == idx_addr(`RFCS_IDX_DATA)) begin
      next_rdata = chan_word(`RFCS_IDX_DATA, data_channel_input_switch);
    end else if (addr_lo == idx_addr(`RFCS_IDX_LEFT)) begin
      next_rdata = chan_word(`RFCS_IDX_LEFT, left_channel_input_switch);
    end else if (addr_lo == idx_addr(`RFCS_IDX_RIGHT)) begin
      next_rdata = chan_word(`RFCS_IDX_RIGHT, right_channel_input_switch);
    end else if (addr_lo == idx_addr(`RFCS_IDX_RADIAL)) begin
      next_rdata = {16'h0000, `RFCS_IDX_RADIAL, radial_offset_and_scale};
    end else if (addr_lo == idx_addr(`RFCS_IDX_CENTRAL)) begin
      next_rdata = {16'h0000, `RFCS_IDX_CENTRAL, central_offset_ab_and_test};
    end else if (addr_lo == `RFCS_ADDR_STATUS) begin
      next_rdata = {24'h00_0000, last_selector, active_channel,
        track_sync, sector_sync};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take & ~hwrite) begin
      hrdata <= next_rdata;
    end
  end

endmodule

// ---- verification/rfcs_regs_monitor.sv ----
// assertion checker for the rf channel select and servo offset register bank
`timescale 1ns/1ns
module rfcs_regs_monitor (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire hready,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] haddr,
  input wire [31:0] hwdata,
  // pins and outputs
  input wire sector_type_pin,
  input wire track_side_pin,
  input wire [1:0] active_channel,
  input wire [1:0] low_freq_path_offset_code,
  input wire offset_scale_select,
  input wire fast_track_bandwidth_select,
  input wire [3:0] radial_e_offset_code,
  input wire [3:0] radial_f_offset_code,
  input wire [5:0] low_freq_offset_mv,
  input wire [10:0] fast_track_bandwidth_khz,
  input wire phase_filter_rf_test_bit,
  input wire [2:0] servo_test_selector,
  input wire [3:0] central_a_offset_code,
  input wire [3:0] central_b_offset_code
);
  // ----
  // command word tracking
  // ----
  reg wr_d;
  reg [2:0] up_cnt;
  wire [3:0] sel = hwdata[15:12];
  wire rad = wr_d && sel == 4'hB;
  wire cen = wr_d && sel == 4'hC;
  wire [1:0] pins = {sector_type_pin, track_side_pin};
  wire [1:0] pin_ch = !pins[1] ? 2'h0 : pins[0] ? 2'h2 : 2'h1;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_d <= 1'b0;
      up_cnt <= 3'h0;
    end else begin
      wr_d <= hsel && hready && htrans[1] && hwrite && haddr[11:2] == 10'h000;
      up_cnt <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // assertions
  // ----
  lf_code_a: assert property (rad |-> ##2 low_freq_path_offset_code == $past(hwdata[11:10], 2))
    else $error("lf code not loaded");
  lf_mv_a: assert property (rad |-> ##2 low_freq_offset_mv ==
    {4'h0, $past(hwdata[11:10], 2)} * ($past(hwdata[9], 2) ? 6'd15 : 6'd5))
    else $error("lf offset mv wrong");
  scale_bit_a: assert property (rad |-> ##2 offset_scale_select == $past(hwdata[9], 2))
    else $error("scale bit not loaded");
  ftc_bw_a: assert property (rad |-> ##2 fast_track_bandwidth_select == $past(hwdata[8], 2)
    && fast_track_bandwidth_khz == ($past(hwdata[8], 2) ? 11'd1200 : 11'd600))
    else $error("fast track bandwidth wrong");
  e_code_a: assert property (rad |-> ##2 radial_e_offset_code == $past(hwdata[7:4], 2))
    else $error("e code not loaded");
  f_code_a: assert property (rad |-> ##2 radial_f_offset_code == $past(hwdata[3:0], 2))
    else $error("f code not loaded");
  central_load_a: assert property (cen |-> ##2 {phase_filter_rf_test_bit,
    servo_test_selector, central_a_offset_code, central_b_offset_code} == $past(hwdata[11:0], 2))
    else $error("central fields not loaded");
  other_reg_a: assert property (wr_d && !rad |-> ##2 $stable({low_freq_path_offset_code,
    offset_scale_select, radial_e_offset_code, radial_f_offset_code}))
    else $error("radial changed by other word");
  chan_pick_a: assert property (up_cnt == 3'h7 && pins == $past(pins) && pins == $past(pins, 2)
    && pins == $past(pins, 3) |-> active_channel == pin_ch)
    else $error("applied channel wrong");
endmodule
bind rfcs_regs rfcs_regs_monitor chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .hready(hready),
  .htrans(htrans),
  .hwrite(hwrite),
  .haddr(haddr),
  .hwdata(hwdata),
  .sector_type_pin(sector_type_pin),
  .track_side_pin(track_side_pin),
  .active_channel(active_channel),
  .low_freq_path_offset_code(low_freq_path_offset_code),
  .offset_scale_select(offset_scale_select),
  .fast_track_bandwidth_select(fast_track_bandwidth_select),
  .radial_e_offset_code(radial_e_offset_code),
  .radial_f_offset_code(radial_f_offset_code),
  .low_freq_offset_mv(low_freq_offset_mv),
  .fast_track_bandwidth_khz(fast_track_bandwidth_khz),
  .phase_filter_rf_test_bit(phase_filter_rf_test_bit),
  .servo_test_selector(servo_test_selector),
  .central_a_offset_code(central_a_offset_code),
  .central_b_offset_code(central_b_offset_code)
);

// ---- verification/rfcs_host_model.sv ----
// host controller model that writes configuration words over the bus
`timescale 1ns/1ns
module rfcs_host_model (
  // clock
  input wire hclk,
  // ahb-lite master
  output reg hsel,
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [31:0] hwdata,
  input wire hreadyout,
  input wire [31:0] hrdata,
  // wait ran out
  output reg bad
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    bad = 1'b0;
  end
  task hold;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 64) begin
        n = n + 1;
        @(posedge hclk);
      end
      if (n == 64) bad = 1'b1;
    end
  endtask
  // single word transfer; released lines show the inverse of the last value
  task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] r);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hold;
      hsel <= 1'b0;
      htrans <= 2'b00;
      haddr <= ~a;
      hwdata <= w ? d : ~hwdata;
      hold;
      r = hrdata;
      hwdata <= ~hwdata;
    end
  endtask
endmodule

// ---- verification/rf_channel_select_and_servo_offset_regs_test.sv ----
// self-checking bench for the rf channel select and servo offset register bank
`timescale 1ns/1ns
module rf_channel_select_and_servo_offset_regs_test;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg sector_type_pin = 1'b0;
  reg track_side_pin = 1'b0;
  wire hsel, hwrite, hreadyout, hresp, bad;
  wire [1:0] htrans, active_channel, low_freq_path_offset_code;
  wire [2:0] hsize, servo_test_selector;
  wire [31:0] haddr, hwdata, hrdata;
  wire input_a_silence, input_b_silence, input_c_silence, input_d_silence;
  wire input_a_polarity_flip, input_b_polarity_flip, input_c_polarity_flip, input_d_polarity_flip;
  wire offset_scale_select, fast_track_bandwidth_select, phase_filter_rf_test_bit;
  wire [3:0] radial_e_offset_code, radial_f_offset_code, central_a_offset_code, central_b_offset_code;
  wire [5:0] low_freq_offset_mv, offset_full_scale_mv;
  wire [10:0] fast_track_bandwidth_khz;
  integer err_count = 0;
  integer n_tests = 0;
  rfcs_regs dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sector_type_pin(sector_type_pin), .track_side_pin(track_side_pin),
    .input_a_silence(input_a_silence), .input_a_polarity_flip(input_a_polarity_flip),
    .input_b_silence(input_b_silence), .input_b_polarity_flip(input_b_polarity_flip),
    .input_c_silence(input_c_silence), .input_c_polarity_flip(input_c_polarity_flip),
    .input_d_silence(input_d_silence), .input_d_polarity_flip(input_d_polarity_flip),
    .active_channel(active_channel),
    .low_freq_path_offset_code(low_freq_path_offset_code),
    .offset_scale_select(offset_scale_select),
    .fast_track_bandwidth_select(fast_track_bandwidth_select),
    .radial_e_offset_code(radial_e_offset_code),
    .radial_f_offset_code(radial_f_offset_code),
    .low_freq_offset_mv(low_freq_offset_mv),
    .offset_full_scale_mv(offset_full_scale_mv),
    .fast_track_bandwidth_khz(fast_track_bandwidth_khz),
    .phase_filter_rf_test_bit(phase_filter_rf_test_bit),
    .servo_test_selector(servo_test_selector),
    .central_a_offset_code(central_a_offset_code),
    .central_b_offset_code(central_b_offset_code)
  );
  rfcs_host_model bus (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .bad(bad)
  );
  always #4 hclk = ~hclk;
  // ----
  // shared tasks
  // ----
  task close_out;
    begin
      if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [15:0] w);
    reg [31:0] r;
    begin
      bus.xfer(1'b1, 32'h0000_0000, {16'h0000, w}, r);
      if (bad) err_count = err_count + 1;
      if (bad) close_out;
      repeat (3) @(posedge hclk);
      #1;
    end
  endtask
  task rd(input [31:0] a, input [31:0] e);
    reg [31:0] r;
    begin
      bus.xfer(1'b0, a, 32'h0000_0000, r);
      if (bad) err_count = err_count + 1;
      if (bad) close_out;
      chk(r, e);
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_chan;
    reg [15:0] w [0:2];
    integer i;
    begin
      w[0] = 16'h8FC3;
      w[1] = 16'h9F5A;
      w[2] = 16'hA6A5;
      for (i = 0; i < 3; i = i + 1) wr(w[i]);
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge hclk);
        sector_type_pin <= (i != 0);
        track_side_pin <= (i != 1);
        repeat (5) @(posedge hclk);
        #1;
        chk(active_channel, i);
        chk({input_d_silence, input_c_silence, input_b_silence, input_a_silence},
          {w[i][7], w[i][5], w[i][3], w[i][1]});
        chk({input_d_polarity_flip, input_c_polarity_flip, input_b_polarity_flip,
          input_a_polarity_flip}, {w[i][6], w[i][4], w[i][2], w[i][0]});
        rd(32'h20 + 4 * i, {16'h0000, w[i][15:12], 4'h0, w[i][7:0]});
      end
    end
  endtask
  task t_central;
    reg [3:0] j;
    begin
      for (j = 0; j < 8; j = j + 1) begin
        wr({4'hC, j[0], j[2:0], j, ~j});
        chk({phase_filter_rf_test_bit, servo_test_selector, central_a_offset_code,
          central_b_offset_code}, {j[0], j[2:0], j, ~j});
      end
      rd(32'h30, 32'h0000_CF78);
    end
  endtask
  task t_radial;
    reg [3:0] k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        wr({4'hB, k[1:0], k[2], k[0], 4'hF - k, k});
        chk(low_freq_path_offset_code, k[1:0]);
        chk(low_freq_offset_mv, k[1:0] * (k[2] ? 15 : 5));
        chk({offset_scale_select, offset_full_scale_mv}, {k[2], k[2] ? 6'd60 : 6'd20});
        chk({fast_track_bandwidth_select, fast_track_bandwidth_khz},
          {k[0], k[0] ? 11'd1200 : 11'd600});
        chk(radial_e_offset_code, 4'hF - k);
        chk(radial_f_offset_code, k);
        chk(central_a_offset_code, 4'h7);
      end
      wr(16'h7FFF);
      wr(16'hDFFF);
      rd(32'h40, 32'h0000_00DB);
      rd(32'h2C, 32'h0000_BF87);
      rd(32'h30, 32'h0000_CF78);
      rd(32'h100, 32'h0000_0000);
    end
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    close_out;
  end
  initial begin
    repeat (16) @(posedge hclk);
    chk({active_channel, offset_full_scale_mv, fast_track_bandwidth_khz}, {2'h3, 6'd20, 11'd600});
    hresetn <= 1'b1;
    t_chan;
    t_central;
    t_radial;
    close_out;
  end
endmodule
